// ---- inc/rd_seq_pkg.sv ----
/*
  Read sequencer constants, states and helpers.
  Assumes a 50 MHz clock.
*/
package rd_seq_pkg;

  // ----------------------------------------------------------------
  // Command byte layout
  // ----------------------------------------------------------------
  localparam int          CMD_BYTES       = 9;
  localparam logic [4:0]  OP_READ_DATA    = 5'h0_006;
  localparam int          BIT_BOTH_SIDES  = 7;
  localparam int          BIT_PASS_DEL    = 5;

  // ----------------------------------------------------------------
  // Result status fields
  // ----------------------------------------------------------------
  localparam logic [1:0]  TERM_NORMAL     = 2'h0;
  localparam logic [1:0]  TERM_ABNORMAL   = 2'h1;
  localparam int          S0_TERM_LSB     = 6;
  localparam int          S0_SEEK_END     = 5;
  localparam int          S0_HEAD_BIT     = 2;
  localparam int          S1_CRC_BIT      = 5;
  localparam int          S1_MISSING_BIT  = 2;
  localparam int          S2_DELETED_BIT  = 6;
  localparam int          S2_ID_CRC_BIT   = 5;
  localparam int          RESULT_BYTES    = 7;

  // ----------------------------------------------------------------
  // Sizes and limits
  // ----------------------------------------------------------------
  localparam int          BASE_SECTOR     = 128;
  localparam logic [2:0]  MAX_SIZE_CODE   = 3'h7;
  localparam logic [7:0]  FIRST_SLOT      = 8'h01;
  localparam int          MISS_MARKS      = 2;
  localparam logic [7:0]  CAP_SLOT_1      = 8'd26;
  localparam logic [7:0]  CAP_SLOT_2      = 8'd15;
  localparam logic [7:0]  CAP_SLOT_3      = 8'd8;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_MHZ         = 50;
  localparam int          SETTLE_US_DEF   = 16;
  localparam int          UNLOAD_US_DEF   = 240;
  localparam int          SETTLE_CYC      = SETTLE_US_DEF * CLK_MHZ;
  localparam int          UNLOAD_CYC      = UNLOAD_US_DEF * CLK_MHZ;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [9:0] {
    ST_IDLE   = 10'b00_0000_0001,
    ST_PARAM  = 10'b00_0000_0010,
    ST_SEEK   = 10'b00_0000_0100,
    ST_SETTLE = 10'b00_0000_1000,
    ST_SCAN   = 10'b00_0001_0000,
    ST_DATA   = 10'b00_0010_0000,
    ST_NEXT   = 10'b00_0100_0000,
    ST_RESULT = 10'b00_1000_0000,
    ST_DONE   = 10'b01_0000_0000,
    ST_SPARE  = 10'b10_0000_0000
  } seq_state_t;

  // Bytes per sector from size code, capped at the largest code
  function automatic logic [14:0] sector_bytes(input logic [7:0] code);
    logic [2:0] c;
    c = (code > 8'(MAX_SIZE_CODE)) ? MAX_SIZE_CODE : code[2:0];
    sector_bytes = 15'(BASE_SECTOR) << c;
  endfunction

endpackage

// ---- verilog/rd_seq_fifo.sv ----
/*
  Sync FIFO with valid/ready on both sides.
  Assumes one clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
module rd_seq_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_wr_data,
  input  wire logic             i_wr_valid,
  output logic                  o_wr_ready,
  output logic      [WIDTH-1:0] o_rd_data,
  output logic                  o_rd_valid,
  input  wire logic             i_rd_ready
);
  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_r;
  logic [AW:0]      rp_r;
  logic             do_wr;
  logic             do_rd;

  // Full when pointers differ only in the wrap bit
  assign o_wr_ready = (wp_r ^ rp_r) != {1'b1, {AW{1'b0}}};
  assign o_rd_valid = wp_r != rp_r;
  assign o_rd_data  = mem[rp_r[AW-1:0]];
  assign do_wr      = i_wr_valid & o_wr_ready;
  assign do_rd      = o_rd_valid & i_rd_ready;

  // Storage
  always_ff @(posedge i_clk_sys) begin
    if (do_wr) begin
      mem[wp_r[AW-1:0]] <= i_wr_data;
    end
  end

  // Pointers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (do_wr) wp_r <= wp_r + 1'b1;
      if (do_rd) rp_r <= rp_r + 1'b1;
    end
  end
endmodule // rd_seq_fifo

// ---- verilog/disk_sector_read_sequencer.sv ----
/*
  Multi-sector disk read sequencer with FIFO and result bytes.
  Assumes a drive front end giving single-cycle strobes on this clock.
*/
// Notes on behaviour
// - Read, write, verify share parameter and result layout.
// - Implied seek runs inside the command.
// - Drive busy bit during seek.
// - Seek failure in status zero; radial byte is cylinder.
// - Load head, settle if unloaded, scan IDs.
// - Matched sector data goes to the FIFO.
// - Slot increments; next sector follows.
// - On stop, send no more; sector ends at CRC.
// - Sector is 128 bytes doubled per size step.
// - Size zero sends partial_length bytes below 128.
// - both_sides_flag reads side 0 then side 1.
// - Final slot capped at 26, 15 or 8.
// - Result IDs follow both_sides_flag, last_slot_number.
// - Head stays up for unload interval.
// - Two rotation marks unmatched: sector_missing_flag.
// - CRC error: crc_fail_flag, id_crc_flag for IDs.
// - Pass clear: deleted sector read, flagged, stop.
// - Slot or radial value increments.
`timescale 1ns/1ps
module disk_sector_read_sequencer
  import rd_seq_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC,
  parameter int UNLOAD_CYCLES = UNLOAD_CYC,
  parameter int FIFO_DEPTH    = 16
) (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_cmd_byte,
  input  wire logic       i_cmd_valid,
  input  wire logic       i_implied_seek_en,
  input  wire logic [7:0] i_present_cylinder,
  output logic            o_seek_req,
  output logic [7:0]      o_seek_target,
  input  wire logic       i_seek_done,
  input  wire logic       i_seek_fail,
  output logic            o_head_load,
  input  wire logic       i_id_valid,
  input  wire logic [7:0] i_id_cyl,
  input  wire logic [7:0] i_id_head,
  input  wire logic [7:0] i_id_slot,
  input  wire logic [7:0] i_id_size,
  input  wire logic       i_id_crc_bad,
  input  wire logic       i_mark_valid,
  input  wire logic       i_mark_deleted,
  input  wire logic [7:0] i_disk_byte,
  input  wire logic       i_disk_byte_valid,
  input  wire logic       i_data_crc_valid,
  input  wire logic       i_data_crc_bad,
  output logic            o_read_gate,
  input  wire logic       i_rotation_mark_pin,
  input  wire logic       i_transfer_stop,
  output logic [7:0]      o_host_data,
  output logic            o_host_valid,
  input  wire logic       i_host_ready,
  output logic [3:0]      o_drive_busy,
  output logic            o_exec_busy,
  output logic [7:0]      o_result_byte,
  output logic            o_result_valid
);

  // ----------------------------------------------------------------
  // Elaboration checks and declarations
  // ----------------------------------------------------------------
  initial begin
    if (SETTLE_CYCLES < 1 || UNLOAD_CYCLES < 1) $error("Timing counts must be positive");
  end

  seq_state_t  state_r;
  logic [7:0]  prm_r [CMD_BYTES];
  logic [3:0]  prm_cnt_r;
  logic [7:0]  cyl_r;
  logic [7:0]  head_r;
  logic [7:0]  slot_r;
  logic [7:0]  s0_r;
  logic [7:0]  s1_r;
  logic [7:0]  s2_r;
  logic [14:0] byte_cnt_r;
  logic [1:0]  marks_r;
  logic        stopping_r;
  logic        skipping_r;
  logic        head_up_r;
  logic [31:0] unload_cnt_r;
  logic [31:0] settle_cnt_r;
  logic [2:0]  res_idx_r;
  logic [2:0]  rot_sync_r;
  logic        stop_sync1_r;
  logic        stop_sync2_r;
  logic        fifo_ready;
  logic        fifo_push;
  logic [7:0]  res_mux;
  logic        rot_edge;
  logic        stop_seen;
  logic        id_match;
  logic [7:0]  last_slot;
  logic [14:0] send_len;
  logic        final_slot;

  // Parameter bytes: 0 opcode, 1 drive/head, 2 cyl, 3 head, 4 slot, 5 size,
  // 6 last slot, 7 gap, 8 partial_length
  assign id_match  = i_id_cyl == cyl_r && i_id_head == head_r
                     && i_id_slot == slot_r && i_id_size == prm_r[5];
  assign last_slot = (prm_r[5] == 8'h01 && prm_r[6] > CAP_SLOT_1) ? CAP_SLOT_1 :
                     (prm_r[5] == 8'h02 && prm_r[6] > CAP_SLOT_2) ? CAP_SLOT_2 :
                     (prm_r[5] == 8'h03 && prm_r[6] > CAP_SLOT_3) ? CAP_SLOT_3 :
                     prm_r[6];
  // sector size / partial length / ignored when nonzero
  assign send_len  = (prm_r[5] == 8'h00 && prm_r[8] < 8'(BASE_SECTOR))
                     ? 15'(prm_r[8]) : sector_bytes(prm_r[5]);
  assign final_slot = slot_r == last_slot;
  assign stop_seen  = stop_sync2_r | (fifo_push & ~fifo_ready);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rot_sync_r   <= '0;
      stop_sync1_r <= 1'b0;
      stop_sync2_r <= 1'b0;
    end else begin
      rot_sync_r   <= {rot_sync_r[1:0], i_rotation_mark_pin};
      stop_sync1_r <= i_transfer_stop;
      stop_sync2_r <= stop_sync1_r;
    end
  end
  assign rot_edge = rot_sync_r[1] & ~rot_sync_r[2];

  // ----------------------------------------------------------------
  // Data FIFO toward the host
  // ----------------------------------------------------------------
  // push matched data / no push once stopping
  assign fifo_push = state_r == ST_DATA && i_disk_byte_valid && !stopping_r
                     && !skipping_r && byte_cnt_r < send_len;

  rd_seq_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_wr_data (i_disk_byte),
    .i_wr_valid(fifo_push),
    .o_wr_ready(fifo_ready),
    .o_rd_data (o_host_data),
    .o_rd_valid(o_host_valid),
    .i_rd_ready(i_host_ready)
  );

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_r    <= ST_IDLE;
      prm_cnt_r  <= '0;
      cyl_r      <= '0;
      head_r     <= '0;
      slot_r     <= '0;
      s0_r       <= '0;
      s1_r       <= '0;
      s2_r       <= '0;
      byte_cnt_r <= '0;
      marks_r    <= '0;
      stopping_r <= 1'b0;
      skipping_r <= 1'b0;
      res_idx_r  <= '0;
      for (int i = 0; i < CMD_BYTES; i++) prm_r[i] <= '0;
    end else begin
      unique case (state_r)
        ST_IDLE, ST_PARAM: begin
          // collect nine bytes / shared layout
          if (i_cmd_valid) begin
            prm_r[prm_cnt_r] <= i_cmd_byte;
            if (32'(prm_cnt_r) == CMD_BYTES - 1) begin
              prm_cnt_r <= '0;
              state_r   <= ST_SEEK;
            end else begin
              prm_cnt_r <= prm_cnt_r + 4'h1;
              state_r   <= ST_PARAM;
            end
          end
        end
        ST_SEEK: begin
          cyl_r      <= prm_r[2];
          head_r     <= prm_r[3];
          slot_r     <= prm_r[4];
          s0_r       <= {5'h00, prm_r[1][2:0]};
          s1_r       <= '0;
          s2_r       <= '0;
          marks_r    <= '0;
          stopping_r <= 1'b0;
          if (!i_implied_seek_en || prm_r[2] == i_present_cylinder || i_seek_done) begin
            state_r <= ST_SETTLE;
          end else if (i_seek_fail) begin
            // seek failure in status zero, cylinder reported
            s0_r[7:6]         <= TERM_ABNORMAL;
            s0_r[S0_SEEK_END] <= 1'b1;
            cyl_r             <= i_present_cylinder;
            state_r           <= ST_RESULT;
          end
        end
        ST_SETTLE: begin
          // wait settling only when head was unloaded
          if (head_up_r && settle_cnt_r == 0) state_r <= ST_SCAN;
        end
        ST_SCAN: begin
          // two rotation marks without a match
          if (rot_edge) marks_r <= marks_r + 2'h1;
          if (rot_edge && 32'(marks_r) == MISS_MARKS - 1) begin
            s0_r[7:6]            <= TERM_ABNORMAL;
            s1_r[S1_MISSING_BIT] <= 1'b1;
            state_r              <= ST_RESULT;
          end else if (i_id_valid && i_id_crc_bad) begin
            s0_r[7:6]           <= TERM_ABNORMAL;
            s1_r[S1_CRC_BIT]    <= 1'b1;
            s2_r[S2_ID_CRC_BIT] <= 1'b1;
            state_r             <= ST_RESULT;
          end else if (i_id_valid && id_match) begin
            byte_cnt_r <= '0;
            skipping_r <= 1'b0;
            state_r    <= ST_DATA;
          end
        end
        ST_DATA: begin
          // mark type decides read or skip
          if (i_mark_valid && i_mark_deleted) begin
            s2_r[S2_DELETED_BIT] <= 1'b1;
            skipping_r           <= prm_r[0][BIT_PASS_DEL];
          end
          // stop sending, sector still runs to its CRC
          if (stop_seen) stopping_r <= 1'b1;
          if (i_disk_byte_valid) byte_cnt_r <= byte_cnt_r + 15'h1;
          if (i_data_crc_valid) begin
            if (i_data_crc_bad && !skipping_r) begin
              s0_r[7:6]        <= TERM_ABNORMAL;
              s1_r[S1_CRC_BIT] <= 1'b1;
              state_r          <= ST_RESULT;
            end else begin
              state_r <= ST_NEXT;
            end
          end
        end
        ST_NEXT: begin
          marks_r <= '0;
          // deleted sector read ends without increment
          if (s2_r[S2_DELETED_BIT] && !skipping_r) begin
            state_r <= ST_RESULT;
          end else if (final_slot) begin
            // last slot, switch side or step cylinder
            slot_r <= FIRST_SLOT;
            if (prm_r[0][BIT_BOTH_SIDES] && !head_r[0]) begin
              head_r[0] <= 1'b1;
              state_r   <= stopping_r ? ST_RESULT : ST_SCAN;
            end else begin
              cyl_r   <= cyl_r + 8'h01;
              if (prm_r[0][BIT_BOTH_SIDES]) head_r[0] <= 1'b0;
              state_r <= ST_RESULT;
            end
          end else begin
            slot_r  <= slot_r + 8'h01;
            state_r <= stopping_r ? ST_RESULT : ST_SCAN;
          end
        end
        ST_RESULT: begin
          s0_r[S0_HEAD_BIT] <= head_r[0];
          res_idx_r         <= '0;
          state_r           <= ST_DONE;
        end
        ST_DONE: begin
          if (o_result_valid && i_cmd_valid) begin
            if (32'(res_idx_r) == RESULT_BYTES - 1) state_r <= ST_IDLE;
            res_idx_r <= res_idx_r + 3'h1;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Head load and unload timing
  // ----------------------------------------------------------------
  // keep head up for the unload interval; reuse skips settling
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      head_up_r    <= 1'b0;
      unload_cnt_r <= '0;
      settle_cnt_r <= '0;
    end else if (state_r == ST_SEEK) begin
      if (!head_up_r) settle_cnt_r <= 32'(SETTLE_CYCLES);
      head_up_r <= 1'b1;
    end else if (state_r == ST_SETTLE || state_r == ST_SCAN || state_r == ST_DATA) begin
      unload_cnt_r <= 32'(UNLOAD_CYCLES);
      if (settle_cnt_r != 0) settle_cnt_r <= settle_cnt_r - 32'h1;
    end else if (unload_cnt_r != 0) begin
      unload_cnt_r <= unload_cnt_r - 32'h1;
    end else begin
      head_up_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_comb begin
    // Look one byte ahead on acknowledge so the new byte stands next cycle
    unique case (res_idx_r + 3'(o_result_valid && i_cmd_valid))
      3'h0:    res_mux = s0_r;
      3'h1:    res_mux = s1_r;
      3'h2:    res_mux = s2_r;
      3'h3:    res_mux = cyl_r;
      3'h4:    res_mux = head_r;
      3'h5:    res_mux = slot_r;
      3'h6:    res_mux = prm_r[5];
      default: res_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_seek_req     <= 1'b0;
      o_seek_target  <= '0;
      o_head_load    <= 1'b0;
      o_read_gate    <= 1'b0;
      o_drive_busy   <= '0;
      o_exec_busy    <= 1'b0;
      o_result_byte  <= '0;
      o_result_valid <= 1'b0;
    end else begin
      o_seek_req     <= state_r == ST_SEEK && i_implied_seek_en
                        && prm_r[2] != i_present_cylinder && !i_seek_done;
      o_seek_target  <= prm_r[2];
      o_drive_busy   <= (state_r == ST_SEEK) ? (4'h1 << prm_r[1][1:0]) : 4'h0;
      o_head_load    <= head_up_r;
      o_read_gate    <= state_r == ST_SCAN || state_r == ST_DATA;
      o_exec_busy    <= state_r != ST_IDLE && state_r != ST_PARAM && state_r != ST_DONE;
      o_result_byte  <= res_mux;
      o_result_valid <= state_r == ST_DONE && !(o_result_valid && i_cmd_valid
                        && 32'(res_idx_r) == RESULT_BYTES - 1);
    end
  end
endmodule // disk_sector_read_sequencer

// ---- test/disk_sector_read_sequencer_checker.sv ----
/* Port-level checker for the sector read sequencer.
   Bound to the top module; sees only its ports. */
`timescale 1ns/1ps
module rd_seq_checker #(
  parameter int SETTLE_CYCLES = 4,
  parameter int UNLOAD_CYCLES = 20,
  parameter int FIFO_DEPTH    = 16
) (
  input wire logic       i_clk_sys,
  input wire logic       i_rst,
  input wire logic       i_cmd_valid,
  input wire logic       i_implied_seek_en,
  input wire logic       i_host_ready,
  input wire logic       o_seek_req,
  input wire logic       o_head_load,
  input wire logic       o_read_gate,
  input wire logic       o_exec_busy,
  input wire logic [3:0] o_drive_busy,
  input wire logic [7:0] o_host_data,
  input wire logic       o_host_valid,
  input wire logic [7:0] o_result_byte,
  input wire logic       o_result_valid
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  // Settle gap
  sequence s_settle;
    !o_read_gate [*4];
  endsequence
  // Shorter than unload
  sequence s_head_kept;
    o_head_load [*8];
  endsequence
  AST_SEEK_AUTO: assert property (
    $rose(o_exec_busy) && i_implied_seek_en |-> ##[0:3] o_seek_req)
    else $error("no implied seek after command");
  AST_SEEK_BUSY: assert property (
    o_seek_req && $past(o_seek_req) |-> o_drive_busy != 4'h0)
    else $error("drive busy low during seek");
  AST_BUSY_ONEHOT: assert property ($onehot0(o_drive_busy))
    else $error("more than one drive busy");
  AST_GATE_HEAD: assert property (
    o_read_gate |-> o_head_load && o_exec_busy)
    else $error("scanning with head unloaded");
  AST_SETTLE: assert property ($rose(o_head_load) |-> s_settle)
    else $error("scan started before settling");
  AST_HEAD_STAYS: assert property (
    $fell(o_read_gate) && o_head_load |=> s_head_kept)
    else $error("head unloaded too early");
  AST_HOST_HOLD: assert property (
    o_host_valid && !i_host_ready |=> o_host_valid && $stable(o_host_data))
    else $error("host byte changed while stalled");
  AST_RESULT_HOLD: assert property (
    o_result_valid && !i_cmd_valid |=> o_result_valid && $stable(o_result_byte))
    else $error("result byte changed unacknowledged");
  AST_RESULT_QUIET: assert property (
    o_result_valid |-> !o_read_gate && !o_seek_req)
    else $error("result phase while disk busy");
endmodule // rd_seq_checker

// ---- test/drive_model.sv ----
/* Behavioural drive and seek engine facing the sequencer.
   Assumes the bench mirrors cylinder, head and size onto the ID bus. */
`timescale 1ns/1ps
module drive_model (
  input  wire logic       i_clk_sys,
  input  wire logic       i_read_gate,
  input  wire logic       i_seek_req,
  input  wire logic [7:0] i_slot,
  input  wire logic [7:0] i_size,
  input  wire logic [3:0] i_fault,   // Miss, deleted, ID CRC, seek fail
  output logic            o_seek_done,
  output logic            o_seek_fail,
  output logic            o_id_valid,
  output logic            o_id_crc_bad,
  output logic [7:0]      o_id_slot,
  output logic            o_mark_valid,
  output logic            o_mark_deleted,
  output logic [7:0]      o_byte,
  output logic            o_byte_valid,
  output logic            o_crc_valid,
  output logic            o_rot_mark
);
  // ----------------------------------------------------------------
  // Seek engine and track
  // ----------------------------------------------------------------
  logic [7:0] slot_r;
  int         k;
  int         idle;
  // Idle levels
  initial begin
    {o_seek_done, o_seek_fail, o_id_valid, o_id_crc_bad, o_mark_valid} = 5'h00;
    {o_mark_deleted, o_byte_valid, o_crc_valid, o_rot_mark} = 4'h0;
    o_id_slot = 8'h00;
    o_byte = 8'h5a;
    idle = 0;
  end
  // Gap tells command from sector
  always @(posedge i_clk_sys) idle <= i_read_gate ? 0 : idle + 1;
  // Seek answers three cycles after the request
  always begin
    @(posedge i_clk_sys iff i_seek_req);
    repeat (3) @(posedge i_clk_sys);
    o_seek_done <= !i_fault[0];
    o_seek_fail <= i_fault[0];
    @(posedge i_clk_sys);
    {o_seek_done, o_seek_fail} <= 2'h0;
    @(posedge i_clk_sys iff !i_seek_req);
  end
  // Sectors while gated
  always begin
    @(posedge i_clk_sys iff i_read_gate);
    if (idle > 6) slot_r = i_slot;
    while (i_read_gate) begin
      if (i_fault[3]) begin
        o_rot_mark <= 1'b1;
        repeat (4) @(posedge i_clk_sys);
        o_rot_mark <= 1'b0;
        repeat (8) @(posedge i_clk_sys);
      end else begin
        repeat (3) @(posedge i_clk_sys);
        {o_id_valid, o_id_crc_bad, o_id_slot} <= {1'b1, i_fault[1], slot_r};
        @(posedge i_clk_sys);
        o_id_valid <= 1'b0;
        {o_mark_valid, o_mark_deleted} <= {1'b1, i_fault[2]};
        @(posedge i_clk_sys);
        o_mark_valid <= 1'b0;
        for (k = 0; k < (128 << i_size) && i_read_gate; k++) begin
          {o_byte_valid, o_byte} <= {1'b1, 8'(k) + slot_r};
          @(posedge i_clk_sys);
        end
        {o_byte_valid, o_byte, o_crc_valid} <= {1'b0, ~o_byte, 1'b1};
        @(posedge i_clk_sys);
        o_crc_valid <= 1'b0;
        slot_r = slot_r + 8'h01;
      end
    end
  end
endmodule // drive_model

// ---- test/test_disk_sector_read_sequencer.sv ----
/* Self-checking bench for the sector read sequencer.
   Drives command and result handshakes; a drive model answers. */
`timescale 1ns/1ps
module test_disk_sector_read_sequencer import rd_seq_pkg::*;;
  localparam logic [7:0] RD  = {3'b000, OP_READ_DATA};
  localparam logic [7:0] RDS = {3'b001, OP_READ_DATA};
  logic       clk, rst, cmd_valid, host_ready, seek_req, seek_done, seek_fail;
  logic       id_valid, id_bad, mark_valid, mark_del, byte_valid, crc_valid, rot, dbad;
  logic       head_load, read_gate, host_valid, exec_busy, res_valid;
  logic [7:0] cmd_byte, c_cyl, c_slot, c_size, id_slot, disk_byte, host_data, res_byte;
  logic [3:0] fault, drive_busy, busy_seen;
  int         fail_count, n_checks;
  logic [7:0] host_q[$];
  disk_sector_read_sequencer #(.SETTLE_CYCLES(4), .UNLOAD_CYCLES(20), .FIFO_DEPTH(16))
  disk_sector_read_sequencer_inst (
    .i_clk_sys(clk), .i_rst(rst), .i_cmd_byte(cmd_byte), .i_cmd_valid(cmd_valid),
    .i_implied_seek_en(!fault[3]), .i_present_cylinder(c_cyl ^ 8'h0f), .o_seek_req(seek_req),
    .o_seek_target(), .i_seek_done(seek_done), .i_seek_fail(seek_fail),
    .o_head_load(head_load), .i_id_valid(id_valid), .i_id_cyl(c_cyl), .i_id_head(8'h00),
    .i_id_slot(id_slot), .i_id_size(c_size), .i_id_crc_bad(id_bad),
    .i_mark_valid(mark_valid), .i_mark_deleted(mark_del), .i_disk_byte(disk_byte),
    .i_disk_byte_valid(byte_valid), .i_data_crc_valid(crc_valid), .i_data_crc_bad(dbad),
    .o_read_gate(read_gate), .i_rotation_mark_pin(rot), .i_transfer_stop(1'b0),
    .o_host_data(host_data), .o_host_valid(host_valid), .i_host_ready(host_ready),
    .o_drive_busy(drive_busy), .o_exec_busy(exec_busy), .o_result_byte(res_byte),
    .o_result_valid(res_valid));
  drive_model drive_model_inst (
    .i_clk_sys(clk), .i_read_gate(read_gate), .i_seek_req(seek_req), .i_slot(c_slot),
    .i_size(c_size), .i_fault(fault), .o_seek_done(seek_done), .o_seek_fail(seek_fail),
    .o_id_valid(id_valid), .o_id_crc_bad(id_bad), .o_id_slot(id_slot),
    .o_mark_valid(mark_valid), .o_mark_deleted(mark_del), .o_byte(disk_byte),
    .o_byte_valid(byte_valid), .o_crc_valid(crc_valid), .o_rot_mark(rot));
  // ----------------------------------------------------------------
  // Clock, watchers and tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Host pops while ready
  always @(posedge clk) if (host_valid === 1'b1 && host_ready === 1'b1) host_q.push_back(host_data);
  always @(posedge clk) if (seek_req === 1'b1 && drive_busy !== 4'h0) busy_seen <= drive_busy;
  task automatic check(input logic [63:0] got, input logic [63:0] want, input string what);
    n_checks++;
    if (got !== want) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  // Nine bytes, seven results, data
  task automatic run(input logic [7:0] op, drv, cyl, slot, last, size, partial_length,
                     input logic [3:0] flt, input logic rdy,
                     input logic [55:0] exp, msk, input int nb, ns);
    logic [7:0]  b[9];
    logic [55:0] res;
    int          t;
    b = '{op, drv, cyl, 8'h00, slot, size, last, 8'h1b, partial_length};
    res = '0;
    @(posedge clk);
    {c_cyl, c_slot, c_size, fault, host_ready, dbad} <= {cyl, slot, size, flt, rdy, op[5]};
    host_q.delete();
    foreach (b[i]) begin
      cmd_byte <= b[i];
      cmd_valid <= 1'b1;
      @(posedge clk);
    end
    cmd_valid <= 1'b0;
    for (int i = 0; i < RESULT_BYTES; i++) begin
      for (t = 0; t < 5000 && res_valid !== 1'b1; t++) @(posedge clk);
      res = {res[47:0], res_byte};
      cmd_valid <= 1'b1;
      @(posedge clk);
      cmd_valid <= 1'b0;
      @(posedge clk);
    end
    host_ready <= 1'b1;
    repeat (40) @(posedge clk);
    check(64'(res & msk), 64'(exp), "result bytes");
    check(64'(host_q.size()), 64'(nb * ns), "host byte count");
    if (nb > 0) foreach (host_q[i]) check(64'(host_q[i]), 64'(8'(i % nb + i / nb) + slot), "data");
    $display("test done at %0t: op %h slot %h", $time, op, slot);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Seven commands, far under this
  initial begin
    #400_000;
    fail_count++;
    results();
  end
  // Levels, reset, scenarios
  initial begin
    {rst, cmd_valid, host_ready, cmd_byte, fault, busy_seen} = {3'b101, 8'h00, 8'h00};
    {c_cyl, c_slot, c_size, dbad} = 25'h000_0000;
    fail_count = 0;
    n_checks = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    run(RD, 8'h00, 8'h05, 8'h01, 8'h02, 8'h00, 8'h04, 4'h0, 1'b1,
        56'h00_0000_0600_0100, 56'hc7_ffff_ffff_ffff, 4, 2);
    run(RD, 8'h00, 8'h05, 8'h01, 8'h01, 8'h00, 8'h04, 4'h8, 1'b1,
        56'h40_0400_0000_0000, 56'hc0_0400_0000_0000, 0, 0);
    run(RD, 8'h00, 8'h05, 8'h03, 8'h04, 8'h00, 8'h02, 4'h4, 1'b1,
        56'h00_0040_0500_0300, 56'hc0_0040_ff00_ff00, 2, 1);
    run(RD, 8'h02, 8'h05, 8'h01, 8'h01, 8'h00, 8'h04, 4'h1, 1'b1,
        56'h62_0000_0a00_0000, 56'he3_0000_ff00_0000, 0, 0);
    check(64'(busy_seen), 64'h0000_0004, "drive busy");
    run(RD, 8'h00, 8'h05, 8'h01, 8'h02, 8'h00, 8'h04, 4'h2, 1'b1,
        56'h40_2020_0000_0000, 56'hc0_2020_0000_0000, 0, 0);
    run(RD, 8'h00, 8'h05, 8'h01, 8'h01, 8'h01, 8'hff, 4'h0, 1'b0,
        56'h00_0000_0600_0101, 56'hc7_ffff_ffff_ffff, 16, 1);
    run(RDS, 8'h00, 8'h05, 8'h01, 8'h02, 8'h00, 8'h04, 4'h4, 1'b1,
        56'h00_0040_0600_0100, 56'hc0_0040_ff00_ff00, 0, 0);
    results();
  end
endmodule // test_disk_sector_read_sequencer

bind disk_sector_read_sequencer rd_seq_checker #(
  .SETTLE_CYCLES(SETTLE_CYCLES), .UNLOAD_CYCLES(UNLOAD_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)
) rd_seq_checker_inst (
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_cmd_valid(i_cmd_valid),
  .i_implied_seek_en(i_implied_seek_en), .i_host_ready(i_host_ready),
  .o_seek_req(o_seek_req), .o_head_load(o_head_load), .o_read_gate(o_read_gate),
  .o_exec_busy(o_exec_busy), .o_drive_busy(o_drive_busy), .o_host_data(o_host_data),
  .o_host_valid(o_host_valid), .o_result_byte(o_result_byte),
  .o_result_valid(o_result_valid));
